// ### design/mrs_dev_end.sv
// Behaviour
// - Frames delimited by 3.5-character idle gaps
// - Diagnosis sub 0000 returns sub and data
// - Diagnosis reply byte-identical including check word
// - Multi-word write carries 1 to 16 words
// - Master sends address, function, start, count, bytes
// - Data words ascending, high byte first
// - Multi-write reply: header, count, fresh check word
// - Values scaled by ten to decimal places
// - Check word last, low byte first
// - Check word starts all ones, covers every byte from station address to last data byte
`timescale 1ns/1ps
`default_nettype none
module mrs_dev_end #(
  parameter int unsigned CHAR_CYC = mrs_pkg::CHAR_CYC,
  parameter int unsigned GAP_CYC = mrs_pkg::GAP_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  mrs_link_if.dev link_io,
  input wire logic [7:0] station_in,
  input wire logic [1:0] dp_in,
  output logic wr_valid_out,
  output logic [15:0] wr_addr_out,
  output logic [15:0] wr_int_out,
  output logic [15:0] wr_frac_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_WRITE = 2'b01,
    ST_TX = 2'b11,
    ST_HOLD = 2'b10
  } mrs_dev_st_type;

  typedef struct packed {
    mrs_dev_st_type st;
    logic [63:0][7:0] fb;
    logic [6:0] len;
    logic ovf;
    logic [15:0] crc;
    logic [mrs_pkg::CNT_W-1:0] idle;
    logic [mrs_pkg::CNT_W-1:0] tmr;
    logic [6:0] idx;
    logic [6:0] dptr;
    logic [6:0] tx_len;
    logic [6:0] tx_last;
    logic tx_crc;
    logic [4:0] wcnt;
    logic [15:0] base;
    logic wv;
    logic [15:0] wa;
    logic [15:0] wi;
    logic [15:0] wf;
    logic sv;
    logic [7:0] sb;
  } mrs_dev_state_type;

  localparam logic [mrs_pkg::CNT_W-1:0] GAP_C = mrs_pkg::CNT_W'(GAP_CYC);
  localparam logic [mrs_pkg::CNT_W-1:0] CHAR_M1 = mrs_pkg::CNT_W'(CHAR_CYC - 1);
  localparam logic [mrs_pkg::CNT_W-1:0] GAP_M1 = mrs_pkg::CNT_W'(GAP_CYC - 1);

  mrs_dev_state_type state_ff;
  mrs_dev_state_type nxt_state;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] cnt;
    logic [15:0] word;
    logic [15:0] scale;
    logic [6:0] dp1;
    logic frame_ok;
    nxt_state = state_ff;
    nxt_state.wv = 1'b0;
    nxt_state.sv = 1'b0;
    cnt = {state_ff.fb[mrs_pkg::POS_CNT_HI[5:0]], state_ff.fb[mrs_pkg::POS_CNT_LO[5:0]]};
    dp1 = state_ff.dptr + 7'h01;
    word = {state_ff.fb[state_ff.dptr[5:0]], state_ff.fb[dp1[5:0]]};
    scale = mrs_pkg::scale_of(dp_in);
    // Bad check word, overflow, runt or foreign station: dropped silently
    frame_ok = !state_ff.ovf && state_ff.crc == mrs_pkg::CRC_RESIDUE
      && state_ff.len >= mrs_pkg::MIN_FRAME
      && state_ff.fb[mrs_pkg::POS_STATION[5:0]] == station_in;
    case (state_ff.st)
      ST_RX: begin
        if (link_io.m2s_valid) begin
          nxt_state.idle = '0;
          if (state_ff.len == mrs_pkg::FB_DEPTH) begin
            nxt_state.ovf = 1'b1;
          end else begin
            nxt_state.fb[state_ff.len[5:0]] = link_io.m2s_byte;
            nxt_state.len = state_ff.len + 7'h01;
          end
          nxt_state.crc = mrs_pkg::crc_upd(state_ff.crc, link_io.m2s_byte);
        end else if (state_ff.idle != GAP_C) begin
          nxt_state.idle = state_ff.idle + 1'b1;
          if (nxt_state.idle == GAP_C && state_ff.len != 7'h00) begin
            nxt_state.len = '0;
            nxt_state.ovf = 1'b0;
            nxt_state.crc = mrs_pkg::CRC_INIT;
            nxt_state.idx = '0;
            nxt_state.tmr = CHAR_M1;
            nxt_state.base = {state_ff.fb[mrs_pkg::POS_ADDR_HI[5:0]], state_ff.fb[mrs_pkg::POS_ADDR_LO[5:0]]};
            if (frame_ok) begin
              case (state_ff.fb[mrs_pkg::POS_FUNC[5:0]])
                mrs_pkg::FUNC_WR_ONE: begin
                  if (state_ff.len == mrs_pkg::LEN_FIXED) begin
                    nxt_state.st = ST_WRITE;
                    nxt_state.wcnt = 5'h01;
                    nxt_state.dptr = mrs_pkg::POS_DATA_ONE;
                    nxt_state.tx_len = state_ff.len;
                    nxt_state.tx_last = state_ff.len - 7'h01;
                    nxt_state.tx_crc = 1'b0;
                  end
                end
                mrs_pkg::FUNC_DIAG: begin
                  // Sub 0000 reuses the captured frame, so the echo is exact
                  if (state_ff.len == mrs_pkg::LEN_FIXED
                      && nxt_state.base == mrs_pkg::DIAG_ECHO_SUB) begin
                    nxt_state.st = ST_TX;
                    nxt_state.tx_len = state_ff.len;
                    nxt_state.tx_last = state_ff.len - 7'h01;
                    nxt_state.tx_crc = 1'b0;
                  end
                end
                mrs_pkg::FUNC_WR_MULTI: begin
                  if (cnt != 16'h0000 && cnt <= mrs_pkg::MAX_WORDS
                      && state_ff.fb[mrs_pkg::POS_BCNT[5:0]] == {2'b00, cnt[4:0], 1'b0}
                      && state_ff.len == mrs_pkg::LEN_MULTI_HDR + {1'b0, cnt[4:0], 1'b0}) begin
                    nxt_state.st = ST_WRITE;
                    nxt_state.wcnt = cnt[4:0];
                    nxt_state.dptr = mrs_pkg::POS_DATA_MULTI;
                    nxt_state.tx_len = mrs_pkg::LEN_RSP_MULTI_BODY;
                    nxt_state.tx_last = mrs_pkg::LEN_RSP_MULTI_BODY + mrs_pkg::CRC_BYTES - 7'h01;
                    nxt_state.tx_crc = 1'b1;
                  end
                end
                default: nxt_state.st = ST_RX;
              endcase
            end
          end
        end
      end
      ST_WRITE: begin
        // One word per cycle, high byte first, ascending addresses
        nxt_state.wv = 1'b1;
        nxt_state.wa = state_ff.base;
        nxt_state.wi = word / scale;
        nxt_state.wf = word % scale;
        nxt_state.base = state_ff.base + 16'h0001;
        nxt_state.dptr = state_ff.dptr + 7'h02;
        nxt_state.wcnt = state_ff.wcnt - 5'h01;
        if (state_ff.wcnt == 5'h01) begin
          nxt_state.st = ST_TX;
        end
      end
      ST_TX: begin
        if (state_ff.tmr != '0) begin
          nxt_state.tmr = state_ff.tmr - 1'b1;
        end else begin
          nxt_state.sv = 1'b1;
          nxt_state.tmr = CHAR_M1;
          nxt_state.idx = state_ff.idx + 7'h01;
          if (state_ff.tx_crc && state_ff.idx == state_ff.tx_len) begin
            nxt_state.sb = state_ff.crc[7:0];
          end else if (state_ff.tx_crc && state_ff.idx == state_ff.tx_len + 7'h01) begin
            nxt_state.sb = state_ff.crc[15:8];
          end else begin
            nxt_state.sb = state_ff.fb[state_ff.idx[5:0]];
            nxt_state.crc = mrs_pkg::crc_upd(state_ff.crc, state_ff.fb[state_ff.idx[5:0]]);
          end
          if (state_ff.idx == state_ff.tx_last) begin
            nxt_state.st = ST_HOLD;
            nxt_state.tmr = GAP_M1;
          end
        end
      end
      ST_HOLD: begin
        // Line must rest a full gap after our reply; input is deaf here
        if (state_ff.tmr != '0) begin
          nxt_state.tmr = state_ff.tmr - 1'b1;
        end else begin
          nxt_state.st = ST_RX;
          nxt_state.idle = '0;
          nxt_state.len = '0;
          nxt_state.crc = mrs_pkg::CRC_INIT;
        end
      end
      default: nxt_state.st = ST_RX;
    endcase
  end

  // ----------------------------------------
  // Register
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_ff <= '0;
      state_ff.st <= ST_RX;
      state_ff.crc <= mrs_pkg::CRC_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign link_io.s2m_valid = state_ff.sv;
  assign link_io.s2m_byte = state_ff.sb;
  assign wr_valid_out = state_ff.wv;
  assign wr_addr_out = state_ff.wa;
  assign wr_int_out = state_ff.wi;
  assign wr_frac_out = state_ff.wf;
endmodule // mrs_dev_end
`default_nettype wire

// ### include/mrs_pkg.sv
`default_nettype none
package mrs_pkg;
  // ----------------------------------------
  // Line timing
  // ----------------------------------------
  localparam longint unsigned CLK_NS = 64'd8;
  localparam longint unsigned BAUD = 64'd19200;
  localparam longint unsigned CHAR_BITS = 64'd11;
  localparam longint unsigned NS_PER_S = 64'd1000000000;
  localparam longint unsigned GAP_CHARS_X2 = 64'd7; // 3.5 characters, doubled
  localparam longint unsigned CHAR_TIME_NS = (CHAR_BITS * NS_PER_S + BAUD - 64'd1) / BAUD;
  localparam longint unsigned GAP_TIME_NS = (GAP_CHARS_X2 * CHAR_TIME_NS + 64'd1) / 64'd2;
  localparam longint unsigned RSP_TIMEOUT_NS = 64'd100000000;
  localparam int unsigned CHAR_CYC = 32'((CHAR_TIME_NS + CLK_NS - 64'd1) / CLK_NS);
  localparam int unsigned GAP_CYC = 32'((GAP_TIME_NS + CLK_NS - 64'd1) / CLK_NS);
  localparam int unsigned RSP_TIMEOUT_CYC = 32'(RSP_TIMEOUT_NS / CLK_NS);
  localparam int unsigned CNT_W = 24;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam logic [7:0] FUNC_WR_ONE = 8'h06;
  localparam logic [7:0] FUNC_DIAG = 8'h08;
  localparam logic [7:0] FUNC_WR_MULTI = 8'h10;
  localparam logic [15:0] DIAG_ECHO_SUB = 16'h0000;
  localparam logic [15:0] MAX_WORDS = 16'h0010;
  localparam logic [6:0] POS_STATION = 7'h00;
  localparam logic [6:0] POS_FUNC = 7'h01;
  localparam logic [6:0] POS_ADDR_HI = 7'h02;
  localparam logic [6:0] POS_ADDR_LO = 7'h03;
  localparam logic [6:0] POS_CNT_HI = 7'h04;
  localparam logic [6:0] POS_CNT_LO = 7'h05;
  localparam logic [6:0] POS_BCNT = 7'h06;
  localparam logic [6:0] POS_DATA_ONE = 7'h04;
  localparam logic [6:0] POS_DATA_MULTI = 7'h07;
  localparam logic [6:0] LEN_FIXED = 7'h08;
  localparam logic [6:0] LEN_MULTI_HDR = 7'h09;
  localparam logic [6:0] LEN_RSP_MULTI_BODY = 7'h06;
  localparam logic [6:0] CRC_BYTES = 7'h02;
  localparam logic [6:0] MIN_FRAME = 7'h04;
  localparam logic [6:0] FB_DEPTH = 7'h40;
  // ----------------------------------------
  // Check word
  // ----------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam int BYTE_BITS = 8;

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < BYTE_BITS; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Fieldbus scale: ten to the number of decimal places
  function automatic logic [15:0] scale_of(input logic [1:0] dp);
    case (dp)
      2'h0: return 16'h0001;
      2'h1: return 16'h000a;
      2'h2: return 16'h0064;
      default: return 16'h03e8;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### include/mrs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mrs_link_if;
  logic m2s_valid;
  logic [7:0] m2s_byte;
  logic s2m_valid;
  logic [7:0] s2m_byte;
  modport dev(input m2s_valid, input m2s_byte, output s2m_valid, output s2m_byte);
  modport mst(output m2s_valid, output m2s_byte, input s2m_valid, input s2m_byte);
endinterface
`default_nettype wire

// ### design/mrs_mst_end.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_mst_end #(
  parameter int unsigned CHAR_CYC = mrs_pkg::CHAR_CYC,
  parameter int unsigned GAP_CYC = mrs_pkg::GAP_CYC,
  parameter int unsigned RSP_TIMEOUT_CYC = mrs_pkg::RSP_TIMEOUT_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  mrs_link_if.mst link_io,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [7:0] req_station_in,
  input wire logic [7:0] req_func_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [4:0] req_count_in,
  input wire logic [1:0] req_dp_in,
  input wire logic [15:0][15:0] req_words_in,
  output logic rsp_valid_out,
  output logic rsp_ok_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_GAP = 2'b01,
    MS_TX = 2'b11,
    MS_RX = 2'b10
  } mrs_mst_st_type;

  typedef struct packed {
    mrs_mst_st_type st;
    logic [7:0] station;
    logic [7:0] func;
    logic [15:0] addr;
    logic [4:0] cnt;
    logic [15:0][15:0] words;
    logic [6:0] idx;
    logic [6:0] tx_len;
    logic [15:0] crc;
    logic [mrs_pkg::CNT_W-1:0] idle;
    logic [mrs_pkg::CNT_W-1:0] tmr;
    logic [6:0] rlen;
    logic [7:0] rb0;
    logic [7:0] rb1;
    logic sv;
    logic [7:0] sb;
    logic rv;
    logic rok;
  } mrs_mst_state_type;

  localparam logic [mrs_pkg::CNT_W-1:0] GAP_C = mrs_pkg::CNT_W'(GAP_CYC);
  localparam logic [mrs_pkg::CNT_W-1:0] CHAR_M1 = mrs_pkg::CNT_W'(CHAR_CYC - 1);
  localparam logic [mrs_pkg::CNT_W-1:0] TIMEOUT_C = mrs_pkg::CNT_W'(RSP_TIMEOUT_CYC);

  mrs_mst_state_type state_ff;
  mrs_mst_state_type nxt_state;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [6:0] d;
    logic [15:0] w;
    logic [7:0] b;
    logic [15:0] scale;
    // Outgoing byte for the current index
    d = state_ff.idx - mrs_pkg::POS_DATA_MULTI;
    w = state_ff.words[d[4:1]];
    b = 8'h00;
    nxt_state = state_ff;
    nxt_state.sv = 1'b0;
    nxt_state.rv = 1'b0;
    scale = mrs_pkg::scale_of(req_dp_in);
    // Gap is timed from the last character on either direction
    if (link_io.m2s_valid || link_io.s2m_valid) begin
      nxt_state.idle = '0;
    end else if (state_ff.idle != GAP_C) begin
      nxt_state.idle = state_ff.idle + 1'b1;
    end
    case (state_ff.idx)
      mrs_pkg::POS_STATION: b = state_ff.station;
      mrs_pkg::POS_FUNC: b = state_ff.func;
      mrs_pkg::POS_ADDR_HI: b = state_ff.addr[15:8];
      mrs_pkg::POS_ADDR_LO: b = state_ff.addr[7:0];
      default: begin
        if (state_ff.func != mrs_pkg::FUNC_WR_MULTI) begin
          b = (state_ff.idx == mrs_pkg::POS_DATA_ONE) ? state_ff.words[0][15:8] : state_ff.words[0][7:0];
        end else if (state_ff.idx == mrs_pkg::POS_CNT_HI) begin
          b = 8'h00;
        end else if (state_ff.idx == mrs_pkg::POS_CNT_LO) begin
          b = {3'b000, state_ff.cnt};
        end else if (state_ff.idx == mrs_pkg::POS_BCNT) begin
          b = {2'b00, state_ff.cnt, 1'b0};
        end else begin
          b = d[0] ? w[7:0] : w[15:8];
        end
      end
    endcase
    case (state_ff.st)
      MS_IDLE: begin
        if (req_valid_in) begin
          nxt_state.st = MS_GAP;
          nxt_state.station = req_station_in;
          nxt_state.func = req_func_in;
          nxt_state.addr = req_addr_in;
          // Count above sixteen is clipped rather than sent
          nxt_state.cnt = (req_count_in == 5'h00) ? 5'h01
            : (req_count_in > 5'(mrs_pkg::MAX_WORDS)) ? 5'(mrs_pkg::MAX_WORDS) : req_count_in;
          for (int k = 0; k < 16; k++) begin
            nxt_state.words[k] = (req_func_in == mrs_pkg::FUNC_DIAG) ? req_words_in[k]
              : 16'(req_words_in[k] * scale);
          end
          nxt_state.tx_len = (req_func_in == mrs_pkg::FUNC_WR_MULTI)
            ? mrs_pkg::LEN_MULTI_HDR - mrs_pkg::CRC_BYTES + {1'b0, nxt_state.cnt, 1'b0}
            : mrs_pkg::LEN_FIXED - mrs_pkg::CRC_BYTES;
        end
      end
      MS_GAP: begin
        if (state_ff.idle == GAP_C) begin
          nxt_state.st = MS_TX;
          nxt_state.idx = '0;
          nxt_state.tmr = CHAR_M1;
          nxt_state.crc = mrs_pkg::CRC_INIT;
        end
      end
      MS_TX: begin
        if (state_ff.tmr != '0) begin
          nxt_state.tmr = state_ff.tmr - 1'b1;
        end else begin
          nxt_state.sv = 1'b1;
          nxt_state.tmr = CHAR_M1;
          nxt_state.idx = state_ff.idx + 7'h01;
          if (state_ff.idx == state_ff.tx_len) begin
            nxt_state.sb = state_ff.crc[7:0];
          end else if (state_ff.idx == state_ff.tx_len + 7'h01) begin
            nxt_state.sb = state_ff.crc[15:8];
            nxt_state.st = MS_RX;
            nxt_state.tmr = '0;
            nxt_state.rlen = '0;
            nxt_state.crc = mrs_pkg::CRC_INIT;
          end else begin
            nxt_state.sb = b;
            nxt_state.crc = mrs_pkg::crc_upd(state_ff.crc, b);
          end
        end
      end
      MS_RX: begin
        if (state_ff.tmr != TIMEOUT_C) begin
          nxt_state.tmr = state_ff.tmr + 1'b1;
        end
        if (link_io.s2m_valid) begin
          nxt_state.rlen = state_ff.rlen + 7'h01;
          nxt_state.crc = mrs_pkg::crc_upd(state_ff.crc, link_io.s2m_byte);
          if (state_ff.rlen == mrs_pkg::POS_STATION) begin
            nxt_state.rb0 = link_io.s2m_byte;
          end
          if (state_ff.rlen == mrs_pkg::POS_FUNC) begin
            nxt_state.rb1 = link_io.s2m_byte;
          end
        end else if ((state_ff.rlen != 7'h00 && state_ff.idle == GAP_C)
            || (state_ff.rlen == 7'h00 && state_ff.tmr == TIMEOUT_C)) begin
          nxt_state.st = MS_IDLE;
          nxt_state.rv = 1'b1;
          nxt_state.rok = state_ff.crc == mrs_pkg::CRC_RESIDUE && state_ff.rlen == mrs_pkg::LEN_FIXED
            && state_ff.rb0 == state_ff.station && state_ff.rb1 == state_ff.func;
        end
      end
      default: nxt_state.st = MS_IDLE;
    endcase
  end

  // ----------------------------------------
  // Register
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_ff <= '0;
      state_ff.st <= MS_IDLE;
      state_ff.crc <= mrs_pkg::CRC_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign req_ready_out = (state_ff.st == MS_IDLE);
  assign link_io.m2s_valid = state_ff.sv;
  assign link_io.m2s_byte = state_ff.sb;
  assign rsp_valid_out = state_ff.rv;
  assign rsp_ok_out = state_ff.rok;
endmodule // mrs_mst_end
`default_nettype wire

// ### test/mrs_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_link_sva #(
  parameter int unsigned CHAR_CYC = 4,
  parameter int unsigned GAP_CYC = 14
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic m2s_valid,
  input wire logic [7:0] m2s_byte,
  input wire logic s2m_valid,
  input wire logic [7:0] s2m_byte,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic wr_valid_out,
  input wire logic rsp_valid_out
);
  // ----------------------------------------
  // Idle counters
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] m_idle;
    logic [7:0] s_idle;
  } mrs_sva_state_type;
  mrs_sva_state_type state_ff;
  mrs_sva_state_type nxt_state;
  int m_idle;
  int s_idle;
  // Saturate so a long silence never wraps into a false gap
  always_comb begin
    nxt_state = state_ff;
    if (state_ff.m_idle != 8'hff) begin
      nxt_state.m_idle = state_ff.m_idle + 8'h01;
    end
    if (state_ff.s_idle != 8'hff) begin
      nxt_state.s_idle = state_ff.s_idle + 8'h01;
    end
    if (m2s_valid) begin
      nxt_state.m_idle = 8'h01;
    end
    if (s2m_valid) begin
      nxt_state.s_idle = 8'h01;
    end
    if (rst_in) begin
      nxt_state = '1;
    end
  end
  always_ff @(posedge mclk_in) begin
    state_ff <= nxt_state;
  end
  assign m_idle = int'(state_ff.m_idle);
  assign s_idle = int'(state_ff.s_idle);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  sequence m_quiet;
    !m2s_valid [*3];
  endsequence
  sequence s_quiet;
    !s2m_valid [*3];
  endsequence
  sequence take_req;
    req_valid_in && req_ready_out;
  endsequence
  AST_M2S_SPACE: assert property (m2s_valid |=> m_quiet)
    else $error("master strobes closer than a character");
  AST_S2M_SPACE: assert property (s2m_valid |=> s_quiet)
    else $error("device strobes closer than a character");
  AST_M2S_FRAMING: assert property (m2s_valid |-> (m_idle == CHAR_CYC || m_idle >= GAP_CYC))
    else $error("master gap neither a character nor a frame gap");
  AST_S2M_FRAMING: assert property (s2m_valid |-> (s_idle == CHAR_CYC || s_idle >= GAP_CYC))
    else $error("device gap neither a character nor a frame gap");
  AST_REPLY_DELAY: assert property (s2m_valid |-> m_idle >= GAP_CYC + CHAR_CYC)
    else $error("device replied before the request was delimited");
  AST_TURNAROUND: assert property (m2s_valid |-> s_idle >= GAP_CYC)
    else $error("master sent without a gap after the reply");
  AST_M2S_HOLD: assert property (m2s_valid |=> $stable(m2s_byte) [*3])
    else $error("master byte changed inside its character");
  AST_S2M_HOLD: assert property (s2m_valid |=> $stable(s2m_byte) [*3])
    else $error("device byte changed inside its character");
  AST_WR_WINDOW: assert property (wr_valid_out |-> m_idle >= GAP_CYC && m_idle <= GAP_CYC + CHAR_CYC + 16)
    else $error("write pulse outside the frame end window");
  AST_BUSY: assert property (take_req |=> !req_ready_out [*8])
    else $error("master ready again while a request runs");
  AST_RSP_PULSE: assert property (rsp_valid_out |-> (s_idle >= GAP_CYC) ##1 !rsp_valid_out)
    else $error("response flagged early or longer than a cycle");
endmodule // mrs_link_sva
`default_nettype wire

// ### test/modbus_rtu_slave_commands_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin fail_count++; $display("MISMATCH t=%0t %s", $time, msg); end end
module modbus_rtu_slave_commands_tb;
  localparam int unsigned CC = 4;
  localparam int unsigned GC = 14;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 32'hb218;
  logic [7:0] station = 8'h02;
  logic [1:0] dev_dp = 2'h0;
  logic req_valid = 1'b0;
  logic [7:0] req_station = 8'h00;
  logic [7:0] req_func = 8'h00;
  logic [15:0] req_addr = 16'h0000;
  logic [4:0] req_count = 5'h00;
  logic [1:0] req_dp = 2'h0;
  logic [15:0][15:0] req_words = '0;
  logic req_ready, rsp_valid, rsp_ok, wr_valid, wr2_valid;
  logic [15:0] wr_addr, wr_int, wr_frac;
  logic [47:0] q_wr[$];
  logic [7:0] q_m2s[$];
  logic [7:0] q_s2m[$];
  logic [7:0] q_s2m2[$];
  logic q_ok[$];
  logic [7:0] f[$];
  logic [7:0] fns[3] = '{8'h06, 8'h08, 8'h10};
  mrs_link_if lnk();
  mrs_link_if lnk2();
  mrs_dev_end #(.CHAR_CYC(CC), .GAP_CYC(GC)) mrs_dev_end_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .link_io(lnk.dev), .station_in(station), .dp_in(dev_dp), .wr_valid_out(wr_valid),
    .wr_addr_out(wr_addr), .wr_int_out(wr_int), .wr_frac_out(wr_frac));
  mrs_dev_end #(.CHAR_CYC(CC), .GAP_CYC(GC)) mrs_dev_end_fault_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .link_io(lnk2.dev), .station_in(8'h01), .dp_in(2'h0), .wr_valid_out(wr2_valid),
    .wr_addr_out(), .wr_int_out(), .wr_frac_out());
  mrs_mst_end #(.CHAR_CYC(CC), .GAP_CYC(GC), .RSP_TIMEOUT_CYC(400)) mrs_mst_end_inst (.mclk_in(mclk_in),
    .rst_in(rst_in), .link_io(lnk.mst), .req_valid_in(req_valid), .req_ready_out(req_ready),
    .req_station_in(req_station), .req_func_in(req_func), .req_addr_in(req_addr), .req_count_in(req_count),
    .req_dp_in(req_dp), .req_words_in(req_words), .rsp_valid_out(rsp_valid), .rsp_ok_out(rsp_ok));
  mrs_link_sva #(.CHAR_CYC(CC), .GAP_CYC(GC)) mrs_link_sva_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .m2s_valid(lnk.m2s_valid), .m2s_byte(lnk.m2s_byte), .s2m_valid(lnk.s2m_valid), .s2m_byte(lnk.s2m_byte),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .wr_valid_out(wr_valid), .rsp_valid_out(rsp_valid));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    lnk2.m2s_valid = 1'b0;
    lnk2.m2s_byte = 8'h00;
    forever #4 mclk_in = ~mclk_in;
  end
  function automatic logic [15:0] crc16(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (d[i]) begin
      c = c ^ {8'h00, d[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  function automatic logic [15:0] p10(input logic [1:0] n);
    return (n == 2'h0) ? 16'h0001 : (n == 2'h1) ? 16'h000a : (n == 2'h2) ? 16'h0064 : 16'h03e8;
  endfunction
  task automatic add_crc(inout logic [7:0] d[$]);
    logic [15:0] c;
    c = crc16(d);
    d = {d, c[7:0], c[15:8]};
  endtask
  // Expectations are queued before the request goes out
  task automatic mreq(input logic [7:0] st, input logic [7:0] fn, input logic [15:0] ad, input logic [4:0] cnt,
                      input string nm);
    logic [7:0] rq[$];
    logic [7:0] rp[$];
    logic [15:0] v;
    int n;
    n = (fn == 8'h10 && cnt != 5'h00) ? int'(cnt) : 1;
    rq = '{st, fn, ad[15:8], ad[7:0]};
    if (fn == 8'h10) begin
      rq = {rq, 8'h00, 8'(n)};
      rp = rq;
      add_crc(rp);
      rq.push_back(8'(2 * n));
    end
    for (int k = 0; k < n; k++) begin
      v = (fn == 8'h08) ? req_words[k] : 16'(req_words[k] * p10(req_dp));
      rq = {rq, v[15:8], v[7:0]};
      if (fn != 8'h08 && st == station) q_wr.push_back({ad + 16'(k), v / p10(dev_dp), v % p10(dev_dp)});
    end
    add_crc(rq);
    if (fn != 8'h10) rp = rq;
    q_m2s = rq;
    if (st == station) q_s2m = rp;
    q_ok.push_back(st == station);
    while (req_ready !== 1'b1) @(negedge mclk_in);
    {req_station, req_func, req_addr, req_count, req_valid} = {st, fn, ad, cnt, 1'b1};
    @(negedge mclk_in);
    req_valid = 1'b0;
    for (int i = 0; i < 3000 && rsp_valid !== 1'b1; i++) @(negedge mclk_in);
    @(negedge mclk_in);
    `CHK(q_m2s.size() + q_s2m.size() + q_wr.size() + q_ok.size(), 0, "expected traffic missing")
    $display("test %s done", nm);
  endtask
  task automatic raw(input logic [7:0] d[$], input logic echo, input string nm);
    repeat (GC + CC) @(negedge mclk_in);
    if (echo) q_s2m2 = d;
    foreach (d[i]) begin
      lnk2.m2s_valid = 1'b1;
      lnk2.m2s_byte = d[i];
      @(negedge mclk_in);
      lnk2.m2s_valid = 1'b0;
      lnk2.m2s_byte = ~d[i];
      repeat (CC - 1) @(negedge mclk_in);
    end
    repeat (GC + 12 * CC + 40) @(negedge mclk_in);
    `CHK(q_s2m2.size(), 0, "reply missing")
    $display("test %s done", nm);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Monitor and stimulus
  // ----------------------------------------
  always @(negedge mclk_in) begin
    if (lnk.m2s_valid === 1'b1) `CHK(lnk.m2s_byte, q_m2s.size() ? q_m2s.pop_front() : ~lnk.m2s_byte, "request byte")
    if (lnk.s2m_valid === 1'b1) `CHK(lnk.s2m_byte, q_s2m.size() ? q_s2m.pop_front() : ~lnk.s2m_byte, "reply byte")
    if (wr_valid === 1'b1) `CHK({wr_addr, wr_int, wr_frac}, q_wr.size() ? q_wr.pop_front() : ~{wr_addr, wr_int, wr_frac}, "write word")
    if (rsp_valid === 1'b1) `CHK(rsp_ok, q_ok.size() ? q_ok.pop_front() : ~rsp_ok, "response status")
    if (lnk2.s2m_valid === 1'b1) `CHK(lnk2.s2m_byte, q_s2m2.size() ? q_s2m2.pop_front() : ~lnk2.s2m_byte, "echo")
    if (wr2_valid === 1'b1) `CHK(wr2_valid, 1'b0, "write from dropped frame")
  end
  initial begin
    repeat (60000) @(posedge mclk_in);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
  initial begin
    repeat (4) @(negedge mclk_in);
    rst_in = 1'b0;
    `CHK(crc16('{8'h02, 8'h06, 8'h00, 8'h04, 8'h13, 8'h88}), 16'h6ec5, "check word reference")
    req_words[0] = 16'h1388;
    mreq(8'h02, 8'h06, 16'h0004, 5'h01, "single write");
    dev_dp = 2'h1;
    req_words[1] = 16'h0032;
    mreq(8'h02, 8'h10, 16'h0004, 5'h02, "multi write scaled");
    mreq(8'h05, 8'h06, 16'h0004, 5'h01, "foreign station");
    mreq(8'h02, 8'h10, 16'h0100, 5'h00, "count zero");
    mreq(8'h02, 8'h10, 16'hfff0, 5'h10, "count sixteen");
    for (int t = 0; t < 8; t++) begin
      dev_dp = 2'($random(seed));
      req_dp = 2'($random(seed));
      foreach (req_words[k]) req_words[k] = 16'($random(seed));
      req_func = fns[$unsigned($random(seed)) % 3];
      req_addr = (req_func == 8'h08) ? 16'h0000 : 16'($random(seed));
      mreq(8'h02, req_func, req_addr, 5'(1 + $unsigned($random(seed)) % 16), "random");
    end
    raw('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'hab, 8'had, 8'h15}, 1'b0, "bad check word");
    f = '{8'h02, 8'h08, 8'h00, 8'h00, 8'h12, 8'hab};
    add_crc(f);
    raw(f, 1'b0, "other station");
    f = '{8'h01, 8'h08, 8'h00, 8'h01, 8'h12, 8'hab};
    add_crc(f);
    raw(f, 1'b0, "unknown sub-function");
    f = '{8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h11, 8'h22};
    repeat (34) f.push_back(8'($random(seed)));
    add_crc(f);
    raw(f, 1'b0, "seventeen words");
    raw('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'hab, 8'had, 8'h14}, 1'b1, "diagnosis echo");
    close_out();
  end
endmodule // modbus_rtu_slave_commands_tb
`default_nettype wire
